// ===== dv/scn_exec_asserts.sv
// Port-level checker for the execution block.
`timescale 1ns/100ps
`include "scn_defs.vh"
module scn_exec_asserts (
  input wire pclk,          // Core clock.
  input wire presetn,       // Reset, active low.
  input wire psel,          // APB select.
  input wire penable,       // APB access phase.
  input wire pwrite,        // APB direction.
  input wire [7:0] paddr,   // APB address.
  input wire [31:0] pwdata, // APB write data.
  input wire [31:0] prdata, // APB read data.
  input wire pready,        // APB ready.
  input wire pslverr,       // APB error.
  input wire busy           // Instruction in flight.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire instr_wr = psel && pwrite && (paddr == `SCN_A_INSTR);
  wire take = acc && pready && instr_wr;
  wire [15:0] op = pwdata[15:0];
  wire one_op = (op == `SCN_POP_OP) || (op == `SCN_PUSH_OP) || (op == `SCN_SOFT_RESET_OP) ||
    (op[15:9] == `SCN_NEGATE_REGISTER_OP);
  wire call_op = op[15:11] == `SCN_RELATIVE_CALL_OP;
  wire ret_op = op[15:1] == `SCN_RETURN_FROM_INTERRUPT_OP;
  // --------
  // Instruction timing
  // --------
  sequence s_one;
    busy [*4] ##[1:6] !busy;
  endsequence
  sequence s_two;
    busy [*8] ##[1:6] !busy;
  endsequence
  property p_busy_one;
    take && one_op |=> s_one;
  endproperty
  a_busy_one: assert property (p_busy_one)
    else $error("single-cycle instruction timing wrong");
  property p_busy_call;
    take && call_op |=> s_two;
  endproperty
  a_busy_call: assert property (p_busy_call)
    else $error("relative call timing wrong");
  property p_busy_ret;
    take && ret_op |=> s_two;
  endproperty
  a_busy_ret: assert property (p_busy_ret)
    else $error("interrupt return timing wrong");
  property p_busy_cause;
    !busy && !take |=> !busy;
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("busy rose without an instruction");
  // --------
  // Bus answers
  // --------
  property p_rdy_free;
    !(instr_wr && busy) |-> pready;
  endproperty
  a_rdy_free: assert property (p_rdy_free)
    else $error("ready low without a pending instruction");
  property p_rdy_stall;
    acc && instr_wr && busy |-> !pready;
  endproperty
  a_rdy_stall: assert property (p_rdy_stall)
    else $error("instruction write accepted while busy");
  property p_err_unmapped;
    acc && (paddr[7:2] > 6'h0d) |-> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped)
    else $error("unmapped access not flagged");
  property p_err_mapped;
    acc && (paddr[7:2] <= 6'h0d) && (paddr[1:0] == 2'h0) |-> !pslverr;
  endproperty
  a_err_mapped: assert property (p_err_mapped)
    else $error("mapped access flagged as error");
  property p_err_data;
    acc && !pwrite && pslverr |-> prdata == 32'h0;
  endproperty
  a_err_data: assert property (p_err_data)
    else $error("unmapped read data not zero");
endmodule

bind scn_exec scn_exec_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .busy(busy));

// ===== dv/stack_call_negate_instr_exec_test.sv
// Self-checking bench for the execution block.
`timescale 1ns/100ps
`include "scn_defs.vh"
module stack_call_negate_instr_exec_test;
  reg pclk;
  reg presetn;
  reg psel;
  reg penable;
  reg pwrite;
  reg [7:0] paddr;
  reg [31:0] pwdata;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire busy;
  int err_count;
  int n_checks;
  logic [31:0] rd;
  logic rerr;

  scn_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic report_and_stop;
  begin
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  end
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
  begin
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  end
  endtask

  task automatic hang(input string what);
  begin
    err_count++;
    $display("unexpected at %0t: no end of wait for %s", $time, what);
    report_and_stop;
  end
  endtask

  // --------
  // Bus master
  // --------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
  begin
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 40);
    if (pready !== 1'b1)
      hang("pready");
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  end
  endtask

  task automatic chk(input logic [7:0] a, input logic [31:0] exp);
  begin
    apb(1'b0, a, 32'h0);
    cmp_word(rd, exp);
  end
  endtask

  task automatic wait_idle;
    int i;
  begin
    for (i = 0; i < 40 && busy !== 1'b0; i++)
      @(posedge pclk);
    if (busy !== 1'b0)
      hang("busy");
  end
  endtask

  task automatic exec(input logic [15:0] op);
  begin
    apb(1'b1, `SCN_A_INSTR, {16'h0, op});
    wait_idle;
  end
  endtask

  // --------
  // Scenarios
  // --------
  task automatic t_reset_values;
  begin
    chk(`SCN_A_PC, 32'h0);
    chk(`SCN_A_STKSTAT, 32'h0);
    apb(1'b1, `SCN_A_STKTOP, 32'h123);
    chk(`SCN_A_STKTOP, 32'h0);
    apb(1'b0, 8'h3c, 32'h0);
    cmp_bit(rerr, 1'b1);
    cmp_word(rd, 32'h0);
  end
  endtask

  task automatic neg_case(input logic [31:0] ctrl, bank, input logic [15:0] op, input logic [31:0] ma, val, res, fl);
  begin
    apb(1'b1, `SCN_A_CTRL, ctrl);
    apb(1'b1, `SCN_A_BANK, bank);
    apb(1'b1, `SCN_A_INDEX, 32'h300);
    apb(1'b1, `SCN_A_MADDR, ma);
    apb(1'b1, `SCN_A_MDATA, val);
    exec(op);
    chk(`SCN_A_MDATA, res);
    chk(`SCN_A_FLAGS, fl);
  end
  endtask

  task automatic t_negate;
  begin
    neg_case(32'h0, 32'h0, 16'h6c10, 32'h010, 32'h3a, 32'hc6, 32'h10);
    neg_case(32'h0, 32'h0, 16'h6c80, 32'hf80, 32'h01, 32'hff, 32'h10);
    neg_case(32'h1, 32'h5, 16'h6d22, 32'h522, 32'hf0, 32'h10, 32'h02);
    neg_case(32'h1, 32'h0, 16'h6c5f, 32'h35f, 32'h81, 32'h7f, 32'h00);
    neg_case(32'h1, 32'h0, 16'h6c60, 32'hf60, 32'h00, 32'h00, 32'h07);
  end
  endtask

  task automatic t_push_pop;
  begin
    apb(1'b1, `SCN_A_CTRL, 32'h0);
    apb(1'b1, `SCN_A_PC, 32'h124);
    apb(1'b1, `SCN_A_FLAGS, 32'h15);
    apb(1'b1, `SCN_A_INSTR, {16'h0, `SCN_PUSH_OP});
    apb(1'b1, `SCN_A_INSTR, {16'h0, `SCN_PUSH_OP});
    wait_idle;
    chk(`SCN_A_STKTOP, 32'h128);
    chk(`SCN_A_STKSTAT, 32'h2);
    exec(`SCN_POP_OP);
    chk(`SCN_A_STKTOP, 32'h126);
    chk(`SCN_A_STKSTAT, 32'h1);
    chk(`SCN_A_FLAGS, 32'h15);
    chk(`SCN_A_PC, 32'h12a);
  end
  endtask

  task automatic t_call_return;
  begin
    apb(1'b1, `SCN_A_PC, 32'h1000);
    exec(16'hdc00);
    chk(`SCN_A_STKTOP, 32'h1002);
    chk(`SCN_A_PC, 32'h802);
    exec(16'hdbff);
    chk(`SCN_A_STKTOP, 32'h804);
    chk(`SCN_A_PC, 32'h1002);
    chk(`SCN_A_STKSTAT, 32'h3);
    apb(1'b1, `SCN_A_PCLAT, 32'h1234);
    apb(1'b1, `SCN_A_SHADOW, 32'h70b5a);
    apb(1'b1, `SCN_A_WREG, 32'h11);
    apb(1'b1, `SCN_A_FLAGS, 32'h0);
    apb(1'b1, `SCN_A_BANK, 32'h0);
    apb(1'b1, `SCN_A_INTEN, 32'h0);
    exec(16'h0011);
    chk(`SCN_A_PC, 32'h804);
    chk(`SCN_A_STKTOP, 32'h1002);
    chk(`SCN_A_WREG, 32'h5a);
    chk(`SCN_A_FLAGS, 32'h0b);
    chk(`SCN_A_BANK, 32'h7);
    chk(`SCN_A_INTEN, 32'h80);
    chk(`SCN_A_PCLAT, 32'h1234);
    apb(1'b1, `SCN_A_CTRL, 32'h2);
    apb(1'b1, `SCN_A_WREG, 32'h33);
    exec(16'h0010);
    chk(`SCN_A_PC, 32'h1002);
    chk(`SCN_A_STKSTAT, 32'h1);
    chk(`SCN_A_WREG, 32'h33);
    chk(`SCN_A_INTEN, 32'hc0);
    chk(`SCN_A_PCLAT, 32'h1234);
  end
  endtask

  task automatic t_soft_reset;
  begin
    exec(16'h0001);
    repeat (31) exec(`SCN_PUSH_OP);
    chk(`SCN_A_STKTOP, 32'h1040);
    chk(`SCN_A_STKSTAT, 32'h91f);
    exec(`SCN_SOFT_RESET_OP);
    chk(`SCN_A_PC, 32'h0);
    chk(`SCN_A_WREG, 32'h0);
    chk(`SCN_A_INTEN, 32'h0);
    chk(`SCN_A_PCLAT, 32'h0);
    chk(`SCN_A_STKSTAT, 32'h0);
    chk(`SCN_A_CTRL, 32'h2);
    exec(`SCN_POP_OP);
    chk(`SCN_A_STKSTAT, 32'h200);
  end
  endtask

  initial
  begin
    err_count = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset_values;
    t_negate;
    t_push_pop;
    t_call_return;
    t_soft_reset;
    report_and_stop;
  end
endmodule

// ===== hdl/scn_exec.v
// Execution unit for negate, stack pop/push, relative call, soft reset and interrupt return.
// Function
// (RULE1) Negate writes the two's complement of the addressed byte back in place.
// (RULE2) Access bit 0 picks the access bank; 1 uses the bank select register.
// (RULE3) Access bit 0, extended set on, operand up to 5Fh: indexed literal offset.
// (RULE4) Pop discards the top entry; the one below becomes top; flags unchanged.
// (RULE5) Push places PC plus two on top, prior top one level down, one cycle.
// (RULE6) Relative call pushes PC plus two before the PC changes.
// (RULE7) Relative call loads PC plus two plus twice the signed offset; second cycle idle.
// (RULE8) Soft reset returns all registers and flags to reset values in one cycle; the control register and memory address keep their values.
// (RULE9) Interrupt return pops the stack into the PC; two cycles, second idle.
// (RULE10) Interrupt return sets the high or the low priority global enable.
// (RULE11) Shadow bit 1 restores working, flags and bank from shadows; 0 leaves them.
// (RULE12) Interrupt return leaves both PC latch registers unchanged.
// (RULE13) Push-type operations advance the stack pointer, pop-type ones retreat it.
`timescale 1ns/100ps
`include "scn_defs.vh"
module scn_exec #(
  parameter MEM_AW = 12,
  parameter STK_DEPTH = 31
)(
  input wire pclk,           // Core clock, 20 MHz.
  input wire presetn,        // Asynchronous reset, active low.
  input wire psel,           // APB select.
  input wire penable,        // APB access phase.
  input wire pwrite,         // APB direction, high for write.
  input wire [7:0] paddr,    // APB byte address.
  input wire [31:0] pwdata,  // APB write data.
  output wire [31:0] prdata, // APB read data.
  output wire pready,        // APB ready.
  output wire pslverr,       // APB error on unmapped address.
  output wire busy           // High while an instruction is pending or running.
);
  localparam ST_IDLE = 3'b001;
  localparam ST_EXEC = 3'b010;
  localparam ST_WAIT = 3'b100;

  reg [2:0] state_ff;
  reg [3:0] q_ff;
  reg pend_ff;
  reg [15:0] instr_ff;
  reg [1:0] ctrl_ff;
  reg [20:0] pc_ff;
  reg [7:0] wreg_ff;
  reg [4:0] flags_ff;
  reg [3:0] bank_select_reg_ff;
  reg high_priority_global_int_enable_ff;
  reg low_priority_global_int_enable_ff;
  reg [7:0] working_reg_shadow_ff;
  reg [4:0] flags_shadow_ff;
  reg [3:0] bank_select_shadow_ff;
  reg [4:0] pc_latch_upper_ff;
  reg [7:0] pc_latch_high_ff;
  reg [MEM_AW-1:0] maddr_ff;
  reg [11:0] index_ff;
  reg badop_ff;
  reg [31:0] prdata_ff;
  reg [7:0] mem [0:(1<<MEM_AW)-1];

  wire [20:0] stack_top_value;
  wire [4:0] stk_ptr;
  wire stk_full;
  wire stk_under;

  // ----------------------------------------------------------------------------
  // Quarter-phase divider: q_ff[3] marks the last phase of an instruction cycle.
  // ----------------------------------------------------------------------------
  wire q4 = q_ff[`SCN_Q_PHASES-1];

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q_ff <= 4'h1;
    else
      q_ff <= {q_ff[2:0], q_ff[3]};
  end

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  wire is_neg = (instr_ff[15:9] == `SCN_NEGATE_REGISTER_OP);
  wire is_pop = (instr_ff == `SCN_POP_OP);
  wire is_push = (instr_ff == `SCN_PUSH_OP);
  wire is_call = (instr_ff[15:11] == `SCN_RELATIVE_CALL_OP);
  wire is_rst = (instr_ff == `SCN_SOFT_RESET_OP);
  wire is_reti = (instr_ff[15:1] == `SCN_RETURN_FROM_INTERRUPT_OP);
  wire is_nop = (instr_ff == `SCN_NOP_OP) || (instr_ff[15:12] == `SCN_NOP_HI);
  wire two_cycle = is_call || is_reti; // RULE7 RULE9
  wire acc_bit = instr_ff[8];
  wire [7:0] freg = instr_ff[7:0];
  wire shadow_bit = instr_ff[0];
  wire run = (state_ff == ST_EXEC) && q4;

  // ----------------------------------------------------------------------------
  // Data memory addressing
  // ----------------------------------------------------------------------------
  reg [11:0] eff_addr;

  always @*
  begin
    if (acc_bit)
      eff_addr = {bank_select_reg_ff, freg}; // RULE2
    else if (ctrl_ff[`SCN_CTRL_EXT] && freg <= `SCN_INDEXED_MAX)
      eff_addr = index_ff + {4'h0, freg}; // RULE3
    else if (freg <= `SCN_INDEXED_MAX)
      eff_addr = {`SCN_ACCESS_LOW_BANK, freg}; // RULE2
    else
      eff_addr = {`SCN_ACCESS_HIGH_BANK, freg}; // RULE2
  end

  wire [MEM_AW-1:0] mem_addr = eff_addr[MEM_AW-1:0];
  wire [7:0] src = mem[mem_addr];
  wire [7:0] neg_val = ~src + 8'h01; // RULE1
  wire [4:0] neg_flags;
  assign neg_flags[`SCN_FL_C] = (src == 8'h00);
  assign neg_flags[`SCN_FL_DC] = (src[3:0] == 4'h0);
  assign neg_flags[`SCN_FL_Z] = (neg_val == 8'h00);
  assign neg_flags[`SCN_FL_OV] = (src == 8'h80);
  assign neg_flags[`SCN_FL_N] = neg_val[7];

  // ----------------------------------------------------------------------------
  // Program counter arithmetic
  // ----------------------------------------------------------------------------
  wire [20:0] pc_next = pc_ff + `SCN_PC_STEP;
  wire [20:0] call_off = {{9{instr_ff[10]}}, instr_ff[10:0], 1'b0};
  wire [20:0] call_dest = pc_next + call_off; // RULE7

  // ----------------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------------
  wire setup = psel && !penable;
  wire access = psel && penable;
  reg mapped;

  always @*
  begin
    case (paddr)
      `SCN_A_CTRL, `SCN_A_INSTR, `SCN_A_PC, `SCN_A_WREG, `SCN_A_FLAGS,
      `SCN_A_BANK, `SCN_A_INTEN, `SCN_A_SHADOW, `SCN_A_STKTOP,
      `SCN_A_STKSTAT, `SCN_A_MADDR, `SCN_A_MDATA, `SCN_A_INDEX, `SCN_A_PCLAT:
        mapped = 1'b1;
      default:
        mapped = 1'b0;
    endcase
  end

  // An instruction write waits while the previous one is still pending or running.
  wire instr_stall = psel && pwrite && (paddr == `SCN_A_INSTR) && (pend_ff || state_ff != ST_IDLE);
  assign pready = !instr_stall;
  assign pslverr = access && !mapped;
  wire wr = access && pwrite && pready && mapped;
  wire wr_cpu = wr && (paddr != `SCN_A_INSTR);
  assign busy = pend_ff || (state_ff != ST_IDLE);

  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h00000000;
    case (paddr)
      `SCN_A_CTRL: rd_mux[1:0] = ctrl_ff;
      `SCN_A_INSTR: rd_mux[15:0] = instr_ff;
      `SCN_A_PC: rd_mux[20:0] = pc_ff;
      `SCN_A_WREG: rd_mux[7:0] = wreg_ff;
      `SCN_A_FLAGS: rd_mux[4:0] = flags_ff;
      `SCN_A_BANK: rd_mux[3:0] = bank_select_reg_ff;
      `SCN_A_INTEN:
      begin
        rd_mux[`SCN_INT_HIGH] = high_priority_global_int_enable_ff;
        rd_mux[`SCN_INT_LOW] = low_priority_global_int_enable_ff;
      end
      `SCN_A_SHADOW:
      begin
        rd_mux[7:0] = working_reg_shadow_ff;
        rd_mux[`SCN_SH_FLAGS_LSB+4:`SCN_SH_FLAGS_LSB] = flags_shadow_ff;
        rd_mux[`SCN_SH_BANK_LSB+3:`SCN_SH_BANK_LSB] = bank_select_shadow_ff;
      end
      `SCN_A_STKTOP: rd_mux[20:0] = stack_top_value;
      `SCN_A_STKSTAT:
      begin
        rd_mux[4:0] = stk_ptr;
        rd_mux[`SCN_SS_FULL] = stk_full;
        rd_mux[`SCN_SS_UNDER] = stk_under;
        rd_mux[`SCN_SS_BUSY] = busy;
        rd_mux[`SCN_SS_BADOP] = badop_ff;
      end
      `SCN_A_MADDR: rd_mux[MEM_AW-1:0] = maddr_ff;
      `SCN_A_MDATA: rd_mux[7:0] = mem[maddr_ff];
      `SCN_A_INDEX: rd_mux[11:0] = index_ff;
      `SCN_A_PCLAT:
      begin
        rd_mux[7:0] = pc_latch_high_ff;
        rd_mux[`SCN_PCLAT_UP_LSB+4:`SCN_PCLAT_UP_LSB] = pc_latch_upper_ff;
      end
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h00000000;
    else if (setup && !pwrite)
      prdata_ff <= rd_mux;
  end

  assign prdata = prdata_ff;

  // ----------------------------------------------------------------------------
  // Sequencer: start on the cycle boundary, act at Q4, idle a cycle if needed.
  // ----------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_ff <= ST_IDLE;
      pend_ff <= 1'b0;
      instr_ff <= 16'h0000;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (wr && paddr == `SCN_A_INSTR)
          begin
            instr_ff <= pwdata[15:0];
            pend_ff <= 1'b1;
          end
          else if (pend_ff && q4)
          begin
            pend_ff <= 1'b0;
            state_ff <= ST_EXEC;
          end
        end
        ST_EXEC:
          if (q4)
            state_ff <= (two_cycle && !is_rst) ? ST_WAIT : ST_IDLE; // RULE7 RULE9
        ST_WAIT:
          if (q4)
            state_ff <= ST_IDLE;
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Return stack
  // ----------------------------------------------------------------------------
  wire stk_push = run && (is_push || is_call); // RULE5 RULE6
  wire stk_pop = run && (is_pop || is_reti); // RULE4 RULE9
  wire soft_rst = run && is_rst; // RULE8

  scn_stack #(
    .DEPTH(STK_DEPTH),
    .AW(21),
    .PW(5)
  ) u_stack (
    .pclk(pclk),
    .presetn(presetn),
    .clear(soft_rst),
    .push(stk_push),
    .pop(stk_pop),
    .push_data(pc_next), // RULE5 RULE6
    .stack_top_value(stack_top_value),
    .stk_ptr(stk_ptr),
    .stk_full(stk_full),
    .stk_under(stk_under)
  );

  // ----------------------------------------------------------------------------
  // Data memory: the core write takes priority over a bus write.
  // ----------------------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (run && is_neg)
      mem[mem_addr] <= neg_val; // RULE1
    else if (wr_cpu && paddr == `SCN_A_MDATA)
      mem[maddr_ff] <= pwdata[7:0];
  end

  // ----------------------------------------------------------------------------
  // Core registers
  // ----------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_ff <= 2'b00;
      pc_ff <= `SCN_RST_PC;
      wreg_ff <= `SCN_RST_BYTE;
      flags_ff <= `SCN_RST_FLAGS;
      bank_select_reg_ff <= `SCN_RST_BANK;
      high_priority_global_int_enable_ff <= 1'b0;
      low_priority_global_int_enable_ff <= 1'b0;
      working_reg_shadow_ff <= `SCN_RST_BYTE;
      flags_shadow_ff <= `SCN_RST_FLAGS;
      bank_select_shadow_ff <= `SCN_RST_BANK;
      pc_latch_upper_ff <= 5'h00;
      pc_latch_high_ff <= `SCN_RST_BYTE;
      maddr_ff <= {MEM_AW{1'b0}};
      index_ff <= `SCN_RST_INDEX;
      badop_ff <= 1'b0;
    end
    else if (soft_rst)
    begin
      pc_ff <= `SCN_RST_PC; // RULE8
      wreg_ff <= `SCN_RST_BYTE;
      flags_ff <= `SCN_RST_FLAGS;
      bank_select_reg_ff <= `SCN_RST_BANK;
      high_priority_global_int_enable_ff <= 1'b0;
      low_priority_global_int_enable_ff <= 1'b0;
      working_reg_shadow_ff <= `SCN_RST_BYTE;
      flags_shadow_ff <= `SCN_RST_FLAGS;
      bank_select_shadow_ff <= `SCN_RST_BANK;
      pc_latch_upper_ff <= 5'h00;
      pc_latch_high_ff <= `SCN_RST_BYTE;
      index_ff <= `SCN_RST_INDEX;
      badop_ff <= 1'b0;
    end
    else if (run)
    begin
      if (is_neg)
      begin
        flags_ff <= neg_flags;
        pc_ff <= pc_next;
      end
      else if (is_call)
        pc_ff <= call_dest; // RULE7
      else if (is_reti)
      begin
        pc_ff <= stack_top_value; // RULE9 RULE12
        if (!ctrl_ff[`SCN_CTRL_PRIO] || !high_priority_global_int_enable_ff)
          high_priority_global_int_enable_ff <= 1'b1; // RULE10
        else
          low_priority_global_int_enable_ff <= 1'b1; // RULE10
        if (shadow_bit)
        begin
          wreg_ff <= working_reg_shadow_ff; // RULE11
          flags_ff <= flags_shadow_ff; // RULE11
          bank_select_reg_ff <= bank_select_shadow_ff; // RULE11
        end
      end
      else
      begin
        pc_ff <= pc_next; // RULE4 RULE5
        if (!(is_pop || is_push || is_nop))
          badop_ff <= 1'b1;
      end
    end
    else if (wr_cpu)
    begin
      case (paddr)
        `SCN_A_CTRL: ctrl_ff <= pwdata[1:0];
        `SCN_A_PC: pc_ff <= pwdata[20:0];
        `SCN_A_WREG: wreg_ff <= pwdata[7:0];
        `SCN_A_FLAGS: flags_ff <= pwdata[4:0];
        `SCN_A_BANK: bank_select_reg_ff <= pwdata[3:0];
        `SCN_A_INTEN:
        begin
          high_priority_global_int_enable_ff <= pwdata[`SCN_INT_HIGH];
          low_priority_global_int_enable_ff <= pwdata[`SCN_INT_LOW];
        end
        `SCN_A_SHADOW:
        begin
          working_reg_shadow_ff <= pwdata[7:0];
          flags_shadow_ff <= pwdata[`SCN_SH_FLAGS_LSB+4:`SCN_SH_FLAGS_LSB];
          bank_select_shadow_ff <= pwdata[`SCN_SH_BANK_LSB+3:`SCN_SH_BANK_LSB];
        end
        `SCN_A_STKSTAT: badop_ff <= badop_ff && !pwdata[`SCN_SS_BADOP];
        `SCN_A_MADDR: maddr_ff <= pwdata[MEM_AW-1:0];
        `SCN_A_INDEX: index_ff <= pwdata[11:0];
        `SCN_A_PCLAT:
        begin
          pc_latch_high_ff <= pwdata[7:0];
          pc_latch_upper_ff <= pwdata[`SCN_PCLAT_UP_LSB+4:`SCN_PCLAT_UP_LSB];
        end
        default: badop_ff <= badop_ff;
      endcase
    end
  end
endmodule

// ===== hdl/scn_stack.v
// Return stack with pointer, top-of-stack view and sticky overflow flags.
`timescale 1ns/100ps
module scn_stack #(
  parameter DEPTH = 31,
  parameter AW = 21,
  parameter PW = 5
)(
  input wire pclk,                  // Core clock.
  input wire presetn,               // Asynchronous reset, active low.
  input wire clear,                 // Empties the stack and clears the flags.
  input wire push,                  // Pushes push_data.
  input wire pop,                   // Discards the top entry.
  input wire [AW-1:0] push_data,    // Value to push.
  output wire [AW-1:0] stack_top_value, // Current top entry.
  output wire [PW-1:0] stk_ptr,     // Number of live entries.
  output wire stk_full,             // Sticky: push attempted when full.
  output wire stk_under             // Sticky: pop attempted when empty.
);
  reg [AW-1:0] ent [1:DEPTH];
  reg [PW-1:0] ptr_ff;
  reg full_ff;
  reg under_ff;
  wire at_top = (ptr_ff == DEPTH[PW-1:0]);
  wire empty = (ptr_ff == {PW{1'b0}});

  // ----------------------------------------------------------------------------
  // Pointer and flags
  // ----------------------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_ff <= {PW{1'b0}};
      full_ff <= 1'b0;
      under_ff <= 1'b0;
    end
    else if (clear)
    begin
      ptr_ff <= {PW{1'b0}};
      full_ff <= 1'b0;
      under_ff <= 1'b0;
    end
    else if (push)
    begin
      if (at_top)
        full_ff <= 1'b1;
      else
        ptr_ff <= ptr_ff + 1'b1; // RULE13
    end
    else if (pop)
    begin
      if (empty)
        under_ff <= 1'b1;
      else
        ptr_ff <= ptr_ff - 1'b1; // RULE13
    end
  end

  // ----------------------------------------------------------------------------
  // Entries
  // ----------------------------------------------------------------------------
  always @(posedge pclk)
  begin
    if (push && !clear && !at_top)
      ent[ptr_ff + 1'b1] <= push_data;
  end

  assign stack_top_value = empty ? {AW{1'b0}} : ent[ptr_ff]; // RULE13
  assign stk_ptr = ptr_ff;
  assign stk_full = full_ff;
  assign stk_under = under_ff;
endmodule

// ===== inc/scn_defs.vh
// Constants for the stack, call, negate and interrupt-return execution block.
`ifndef SCN_DEFS_VH
`define SCN_DEFS_VH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SCN_A_CTRL 8'h00
`define SCN_A_INSTR 8'h04
`define SCN_A_PC 8'h08
`define SCN_A_WREG 8'h0c
`define SCN_A_FLAGS 8'h10
`define SCN_A_BANK 8'h14
`define SCN_A_INTEN 8'h18
`define SCN_A_SHADOW 8'h1c
`define SCN_A_STKTOP 8'h20
`define SCN_A_STKSTAT 8'h24
`define SCN_A_MADDR 8'h28
`define SCN_A_MDATA 8'h2c
`define SCN_A_INDEX 8'h30
`define SCN_A_PCLAT 8'h34

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SCN_CTRL_EXT 0
`define SCN_CTRL_PRIO 1
`define SCN_FL_C 0
`define SCN_FL_DC 1
`define SCN_FL_Z 2
`define SCN_FL_OV 3
`define SCN_FL_N 4
`define SCN_INT_HIGH 7
`define SCN_INT_LOW 6
`define SCN_SH_FLAGS_LSB 8
`define SCN_SH_BANK_LSB 16
`define SCN_SS_FULL 8
`define SCN_SS_UNDER 9
`define SCN_SS_BUSY 10
`define SCN_SS_BADOP 11
`define SCN_PCLAT_UP_LSB 8

// ----------------------------------------------------------------------------
// Opcodes and operand limits
// ----------------------------------------------------------------------------
`define SCN_NEGATE_REGISTER_OP 7'h36
`define SCN_RELATIVE_CALL_OP 5'h1b
`define SCN_RETURN_FROM_INTERRUPT_OP 15'h0008
`define SCN_POP_OP 16'h0006
`define SCN_PUSH_OP 16'h0005
`define SCN_SOFT_RESET_OP 16'h00ff
`define SCN_NOP_OP 16'h0000
`define SCN_NOP_HI 4'hf
`define SCN_INDEXED_MAX 8'h5f
`define SCN_ACCESS_LOW_BANK 4'h0
`define SCN_ACCESS_HIGH_BANK 4'hf

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define SCN_RST_PC 21'h000000
`define SCN_RST_BYTE 8'h00
`define SCN_RST_FLAGS 5'h00
`define SCN_RST_BANK 4'h0
`define SCN_RST_INDEX 12'h000
`define SCN_PC_STEP 21'h000002
`define SCN_Q_PHASES 4

`endif
